// ### logic/srl_top.sv
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
// Function
// R1: Latch enable bit turns the latch function on; zero disables it.
// R2: Divider field gives a one-cycle pulse every 4 to 512 cycles.
// R3: True output pin shows Q when latch and its enable are set.
// R4: Inverted output pin shows not-Q when latch and its enable set.
// R5: Writing one to software set bit pulses set for one cycle.
// R6: Writing one to software reset bit pulses reset for one cycle.
// R7: Software set and reset bits are write-only and read zero.
// R8: Pin-set enable lets a high input pin set the latch.
// R9: Clock-set enable lets the divider pulse set the latch.
// R10: Comparator-set enable lets a high comparator output set the latch.
// R11: Pin-reset enable lets a high input pin reset the latch.
// R12: Clock-reset enable lets the divider pulse reset the latch.
// R13: Comparator-reset enable lets a high comparator output reset the latch.
// R14: Reserved source-select bits read zero; software keeps them zero.
// R15: Both control registers clear to zero on every reset.
// R16: Reset wins when set and reset are asserted together.
// R17: All set and reset sources are active-high.
// R18: Software must force the latch to a known state before output.
// R19: Set term ORs enabled set sources; reset term ORs reset sources.
module srl_top (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Latch sources
    input wire logic external_latch_input_pin,
    input wire logic comparator_output,
    // Latch outputs
    output logic true_output_pin,
    output logic inverted_output_pin
);
    logic [7:0] ctrl_r;
    logic [7:0] src_r;
    logic sw_set_r;
    logic sw_rst_r;
    logic q_r;
    logic [srl_pkg::div_w-1:0] div_cnt_r;
    logic div_pulse_r;
    logic pin_s;
    logic cmp_s;
    logic set_term;
    logic rst_term;
    logic wr_acc;
    logic rd_acc;
    logic [srl_pkg::div_w-1:0] period;
    logic ctrl_wr;
    logic src_wr;
    logic setup_cyc;
    logic div_wrap;
    logic latch_on;

    function automatic logic [srl_pkg::div_w-1:0] div_period(input logic [2:0] code);
        div_period = srl_pkg::div_base << code;
    endfunction : div_period

    // Register decode is shared by the write path, the pulses and the error flag
    function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] off);
        addr_is = (addr == off);
    endfunction : addr_is

    function automatic logic addr_mapped(input logic [7:0] addr);
        addr_mapped = addr_is(addr, srl_pkg::ctrl_off)
            || addr_is(addr, srl_pkg::src_off)
            || addr_is(addr, srl_pkg::stat_off);
    endfunction : addr_mapped

    // Pulse bits are never stored, so they always read back as zero
    function automatic logic [7:0] ctrl_store(input logic [7:0] wd);
        ctrl_store = wd;
        ctrl_store[srl_pkg::sps_bit] = 1'b0; // R7
        ctrl_store[srl_pkg::spr_bit] = 1'b0; // R7
    endfunction : ctrl_store

    // Reserved positions are forced clear even if software breaks the rule
    function automatic logic [7:0] src_store(input logic [7:0] wd);
        src_store = wd;
        src_store[srl_pkg::rsv_hi_bit] = 1'b0; // R14
        src_store[srl_pkg::rsv_lo_bit] = 1'b0; // R14
    endfunction : src_store

    // A pin follows its level only while the latch and that pin's enable are on
    function automatic logic pin_drive(input logic active, input logic oen, input logic lvl);
        pin_drive = active & oen & lvl;
    endfunction : pin_drive

    // Only the low byte is implemented; upper bits and unmapped words read zero
    function automatic logic [31:0] read_word(input logic [7:0] addr, input logic [7:0] ctrl,
        input logic [7:0] src, input logic q);
        if (addr_is(addr, srl_pkg::ctrl_off))
        begin
            read_word = {24'h000000, ctrl}; // R7
        end
        else if (addr_is(addr, srl_pkg::src_off))
        begin
            read_word = {24'h000000, src}; // R14
        end
        else if (addr_is(addr, srl_pkg::stat_off))
        begin
            read_word = {{31{1'b0}}, q};
        end
        else
        begin
            read_word = '0;
        end
    endfunction : read_word

    // Pin crosses domains; comparator is treated as asynchronous too
    srl_sync u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .d_in(external_latch_input_pin),
        .d_out(pin_s)
    );
    srl_sync u_cmp_sync (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .d_in(comparator_output),
        .d_out(cmp_s)
    );

    // Zero-wait-state slave: answer in the access cycle
    assign wr_acc = psel && penable && pwrite && clk_en;
    assign rd_acc = psel && !penable && !pwrite && clk_en;
    assign setup_cyc = psel && !penable;
    // Only byte lane zero carries register data
    assign ctrl_wr = wr_acc && pstrb[0] && addr_is(paddr, srl_pkg::ctrl_off);
    assign src_wr = wr_acc && pstrb[0] && addr_is(paddr, srl_pkg::src_off);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= srl_pkg::ctrl_rst; // R15
        end
        else if (ctrl_wr)
        begin
            ctrl_r <= ctrl_store(pwdata[7:0]);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            src_r <= srl_pkg::src_rst; // R15
        end
        else if (src_wr)
        begin
            src_r <= src_store(pwdata[7:0]);
        end
    end

    // Self-clearing one-cycle software pulses; writing zero does nothing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sw_set_r <= 1'b0;
        end
        else if (clk_en)
        begin
            sw_set_r <= ctrl_wr && pwdata[srl_pkg::sps_bit]; // R5
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sw_rst_r <= 1'b0;
        end
        else if (clk_en)
        begin
            sw_rst_r <= ctrl_wr && pwdata[srl_pkg::spr_bit]; // R6
        end
    end

    assign period = div_period(ctrl_r[srl_pkg::div_hi:srl_pkg::div_lo]);

    // Free-running divider; the compare makes a shorter code take effect at once
    assign div_wrap = (div_cnt_r >= period - srl_pkg::div_w'(1));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt_r <= '0;
        end
        else if (clk_en)
        begin
            if (div_wrap)
            begin
                div_cnt_r <= '0;
            end
            else
            begin
                div_cnt_r <= div_cnt_r + srl_pkg::div_w'(1);
            end
        end
    end

    // Pulse is one clock wide, once per wrap of the counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_pulse_r <= 1'b0;
        end
        else if (clk_en)
        begin
            div_pulse_r <= div_wrap; // R2
        end
    end

    // Active-high sources, OR-combined per side
    assign set_term = sw_set_r // R19
        | (src_r[srl_pkg::pse_bit] & pin_s) // R8 R17
        | (src_r[srl_pkg::cse_bit] & div_pulse_r) // R9
        | (src_r[srl_pkg::kse_bit] & cmp_s); // R10
    assign rst_term = sw_rst_r // R19
        | (src_r[srl_pkg::pre_bit] & pin_s) // R11 R17
        | (src_r[srl_pkg::cre_bit] & div_pulse_r) // R12
        | (src_r[srl_pkg::kre_bit] & cmp_s); // R13

    // The latch has no defined state after reset; clearing it here only keeps
    // simulation free of unknowns, so software must still set or clear it
    // before it turns an output pin on
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (rst_term)
            begin
                q_r <= 1'b0; // R16
            end
            else if (set_term)
            begin
                q_r <= 1'b1;
            end
        end
    end

    // Outputs off while the latch is disabled
    assign latch_on = ctrl_r[srl_pkg::en_bit]; // R1

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            true_output_pin <= 1'b0;
        end
        else if (clk_en)
        begin
            true_output_pin <= pin_drive(latch_on, ctrl_r[srl_pkg::qen_bit], q_r); // R3
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            inverted_output_pin <= 1'b0;
        end
        else if (clk_en)
        begin
            inverted_output_pin <= pin_drive(latch_on, ctrl_r[srl_pkg::nqen_bit], ~q_r); // R4
        end
    end

    // Ready is registered from the setup cycle, so no access ever waits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (clk_en)
        begin
            pready <= setup_cyc;
            pslverr <= setup_cyc && !addr_mapped(paddr);
        end
    end

    // Read data captured in setup so that it stands through the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
        end
        else if (rd_acc)
        begin
            prdata <= read_word(paddr, ctrl_r, src_r, q_r); // R7 R14
        end
    end
endmodule : srl_top

// ### logic/srl_pkg.sv
package srl_pkg;
    // Register byte offsets on the APB
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] src_off = 8'h04;
    localparam logic [7:0] stat_off = 8'h08;
    // Primary control fields
    localparam int en_bit = 7;
    localparam int div_hi = 6;
    localparam int div_lo = 4;
    localparam int qen_bit = 3;
    localparam int nqen_bit = 2;
    localparam int sps_bit = 1;
    localparam int spr_bit = 0;
    // Source select fields
    localparam int pse_bit = 7;
    localparam int cse_bit = 6;
    localparam int rsv_hi_bit = 5;
    localparam int kse_bit = 4;
    localparam int pre_bit = 3;
    localparam int cre_bit = 2;
    localparam int rsv_lo_bit = 1;
    localparam int kre_bit = 0;
    // Reset values
    localparam logic [7:0] ctrl_rst = 8'h00;
    localparam logic [7:0] src_rst = 8'h00;
    // Divider: period is 4 shifted left by the field code
    localparam logic [9:0] div_base = 10'h004;
    localparam int div_w = 10;
endpackage : srl_pkg

// ### logic/srl_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser; a change counts once stages two and three agree
module srl_sync (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // Data
    input wire logic d_in,
    output logic d_out
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            d_out <= 1'b0;
        end
        else if (clk_en)
        begin
            s1_r <= d_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
            begin
                d_out <= s3_r;
            end
        end
    end
endmodule : srl_sync

// ### dv/srl_properties.sv
`timescale 1ns/1ps
module srl_properties (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Latch pins
    input wire logic true_output_pin,
    input wire logic inverted_output_pin
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_c;
    logic rd;
    assign wr_c = pready && pwrite && pstrb[0] && paddr == srl_pkg::ctrl_off;
    assign rd = pready && !pwrite;
    sequence s_setup;
        psel && !penable ##1 psel && penable;
    endsequence
    sequence s_ctl(logic [7:0] d);
        wr_c && pwdata[7:0] == d;
    endsequence
    a_ready_access: assert property (s_setup |-> pready)
        else $error("no ready in access");
    a_ready_once: assert property (pready |=> !pready)
        else $error("ready held");
    a_pulse_zero: assert property (rd && paddr == srl_pkg::ctrl_off |-> prdata[1:0] == 2'h0)
        else $error("pulse bits read one");
    a_rsv_zero: assert property (rd && paddr == srl_pkg::src_off |-> !prdata[5] && !prdata[1])
        else $error("reserved bits read one");
    a_outs_apart: assert property (!(true_output_pin && inverted_output_pin))
        else $error("both outputs high");
    a_soft_reset: assert property (s_ctl(8'h85) |-> ##[2:4] inverted_output_pin)
        else $error("soft reset lost");
    a_soft_set: assert property (s_ctl(8'h8a) |-> ##[2:4] true_output_pin)
        else $error("soft set lost");
    a_reset_wins: assert property (s_ctl(8'h8f) |-> ##[2:4] !true_output_pin)
        else $error("set beat reset");
    a_off_disabled: assert property (wr_c && !pwdata[7] |-> ##2 !true_output_pin && !inverted_output_pin)
        else $error("output while disabled");
endmodule : srl_properties

bind srl_top srl_properties i_srl_properties (
    .pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .true_output_pin(true_output_pin), .inverted_output_pin(inverted_output_pin)
);

// ### dv/srl_src_model.sv
`timescale 1ns/1ps
module srl_src_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Requested levels
    input wire logic [1:0] lvl,
    // Source lines
    output logic pin,
    output logic cmp
);
    // Levels move only after an edge, like a clean external source
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin <= 1'b0;
            cmp <= 1'b0;
        end
        else
        begin
            pin <= lvl[0];
            cmp <= lvl[1];
        end
    end
endmodule : srl_src_model

// ### dv/srl_top_tb.sv
`timescale 1ns/1ps
module srl_top_tb;
    localparam logic [7:0] ctl = srl_pkg::ctrl_off;
    localparam logic [7:0] srr = srl_pkg::src_off;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [1:0] lvl = 2'h0;
    logic [31:0] prdata, rdv;
    logic pready, pslverr, ev, external_latch_input_pin, comparator_output;
    logic true_output_pin, inverted_output_pin;
    int n_errors = 0;
    int n_checks = 0;
    always #5 pclk = ~pclk;
    srl_top i_srl_top (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_latch_input_pin(external_latch_input_pin),
        .comparator_output(comparator_output),
        .true_output_pin(true_output_pin), .inverted_output_pin(inverted_output_pin)
    );
    srl_src_model i_srl_src_model (.pclk, .presetn, .lvl,
        .pin(external_latch_input_pin), .cmp(comparator_output));
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, s, e);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        chk(n < 20, 1'b1);
        rdv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rd(input logic [7:0] a, input logic [7:0] e, input logic err);
        apb(1'b0, a, 8'h00);
        chk(rdv, {24'h0, e});
        chk(ev, err);
    endtask : rd
    // Polls the pins; sources pass a synchroniser so the delay is a few cycles
    task wo(input logic [1:0] e);
        int n;
        n = 0;
        while ({true_output_pin, inverted_output_pin} !== e && n < 30)
        begin
            @(negedge pclk);
            n++;
        end
        chk({true_output_pin, inverted_output_pin}, e);
    endtask : wo
    task t_regs;
        rd(ctl, 8'h00, 1'b0);
        rd(srr, 8'h00, 1'b0);
        apb(1'b1, srr, 8'hdd);
        rd(srr, 8'hdd, 1'b0);
        pstrb <= 4'h0;
        apb(1'b1, srr, 8'h00);
        pstrb <= 4'hf;
        rd(srr, 8'hdd, 1'b0);
        apb(1'b1, srr, 8'h00);
        // Both pulses with the pins off, so the latch is known before a pin turns on
        apb(1'b1, ctl, 8'h7f);
        rd(ctl, 8'h7c, 1'b0);
        rd(8'h0c, 8'h00, 1'b1);
        $display("register test done");
    endtask : t_regs
    task t_soft;
        apb(1'b1, ctl, 8'h85);
        wo(2'b01);
        apb(1'b1, ctl, 8'h8a);
        wo(2'b10);
        rd(srl_pkg::stat_off, 8'h01, 1'b0);
        apb(1'b1, ctl, 8'h8f);
        wo(2'b01);
        apb(1'b1, ctl, 8'h0e);
        wo(2'b00);
        $display("software pulse test done");
    endtask : t_soft
    task t_src;
        apb(1'b1, ctl, 8'h8d);
        apb(1'b1, srr, 8'h80);
        lvl <= 2'b01;
        wo(2'b10);
        apb(1'b1, srr, 8'h08);
        wo(2'b01);
        apb(1'b1, srr, 8'h10);
        lvl <= 2'b11;
        wo(2'b10);
        apb(1'b1, srr, 8'h01);
        wo(2'b01);
        apb(1'b1, srr, 8'h00);
        apb(1'b1, ctl, 8'h8e);
        repeat (10) @(posedge pclk);
        wo(2'b10);
        apb(1'b1, ctl, 8'h8d);
        wo(2'b01);
        apb(1'b1, srr, 8'h40);
        wo(2'b10);
        $display("source test done");
    endtask : t_src
    // With the clock enable low neither the synchroniser nor the latch may move
    task t_hold;
        apb(1'b1, srr, 8'h00);
        lvl <= 2'b00;
        apb(1'b1, ctl, 8'h8d);
        wo(2'b01);
        apb(1'b1, srr, 8'h80);
        clk_en <= 1'b0;
        lvl <= 2'b01;
        repeat (20) @(posedge pclk);
        chk({true_output_pin, inverted_output_pin}, 2'b01);
        clk_en <= 1'b1;
        wo(2'b10);
        $display("clock enable test done");
    endtask : t_hold
    // Pin holds set while the divider pulses reset, so the inverted pin blips once a period
    task t_div;
        int c;
        apb(1'b1, srr, 8'h84);
        lvl <= 2'b01;
        for (int k = 0; k < 8; k++)
        begin
            apb(1'b1, ctl, {1'b1, 3'(k), 4'h4});
            for (int j = 0; j < 3; j++)
            begin
                c = 0;
                do @(negedge pclk); while (inverted_output_pin !== 1'b1 && ++c < 600);
            end
            chk(c + 1, 4 << k);
        end
        $display("divider test done");
    endtask : t_div
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_soft;
        t_src;
        t_hold;
        t_div;
        test_done;
    end
    initial
    begin
        #200000;
        n_errors++;
        test_done;
    end
endmodule : srl_top_tb
